// file: core/hom_pkg.sv
// Overview of operation
// - A remote wake-up is signalled while the remote wake-up enable bit and the resume-detected flag are both set.
// - The remote wake-up enable bit has no effect on whether hardware interrupts are raised.
// - The remote-wake-connected bit clears on hardware reset and keeps its value across a software reset.
// - A two-bit functional state at bits 7 to 6 codes reset 00, resume 01, operational 10, suspend 11, and entering operational starts frame-start generation 1 ms later.
// - The controller changes the functional state on its own only while it holds suspend; otherwise only driver writes, software reset and hardware reset change it.
// - From suspend the controller may move the functional state to resume after it detects resume signalling on the bus.
// - The register is read with command code 01 and written with command code 81.
// - A software reset forces the functional state to suspend from any state and completes within 10 ms.
// - The onset of frame-start generation is made visible by setting the frame-start flag in the event status register.
package hom_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // command codes and field layout
   localparam logic [7:0] CMD_READ = 8'h01;
   localparam logic [7:0] CMD_WRITE = 8'h81;
   localparam int RWE_BIT = 10;
   localparam int RWC_BIT = 9;
   localparam int FS_LSB = 6;
   localparam int FS_MSB = 7;
   localparam logic RWE_RESET = 1'b0;
   localparam logic RWC_RESET = 1'b0;
   localparam logic [31:0] RD_RESET = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_HZ = 25_000_000;
   localparam int SOF_DELAY_MS = 1;
   localparam int SOF_DELAY_CYCLES = (CLK_HZ / 1000) * SOF_DELAY_MS;
   localparam int SOFT_RESET_MAX_MS = 10;
   localparam int SOFT_RESET_MAX_CYCLES = (CLK_HZ / 1000) * SOFT_RESET_MAX_MS;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {
      state_bus_reset,
      state_bus_resume,
      state_bus_operational,
      state_bus_suspend
   } hom_fs_t;

   // one command from the processor port
   typedef struct packed {
      logic valid;
      logic [7:0] code;
      logic [31:0] data;
   } hom_cmd_t;

   // read answer back to the processor port
   typedef struct packed {
      logic valid;
      logic [31:0] data;
   } hom_rsp_t;

   // state of the mode register block, apart from the frame-start timer held in hom_sof_timer
   typedef struct packed {
      logic remote_wake_enable;
      logic remote_wake_connected;
      hom_fs_t host_functional_state;
      hom_rsp_t rsp;
      logic wakeup;
      logic sof_active;
      logic reset_done;
      logic resume_s1;
      logic resume_s2;
   } hom_state_t;

endpackage

// file: core/hom_sof_timer.sv
`timescale 1ns/1ps
module hom_sof_timer #(
   parameter int DELAY_CYCLES = hom_pkg::SOF_DELAY_CYCLES,
   parameter int CW = $clog2(DELAY_CYCLES + 1)
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic start,
   input wire logic abort,
   output logic fire
);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic run;
      logic fire;
   } hom_tmr_t;

   localparam logic [CW-1:0] LOAD = CW'(DELAY_CYCLES - 1);

   hom_tmr_t st_q;
   hom_tmr_t st_d;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // countdown from operational entry to the first frame start
   always_comb begin
      st_d = st_q;
      st_d.fire = 1'b0;
      if (start) begin
         st_d.cnt = LOAD;
         st_d.run = 1'b1;
      end else if (abort) begin
         st_d.run = 1'b0;
      end else if (st_q.run) begin
         if (st_q.cnt == '0) begin
            st_d.fire = 1'b1;
            st_d.run = 1'b0;
         end else begin
            st_d.cnt = st_q.cnt - CW'(1);
         end
      end
   end

   // state register, frozen while ce is low
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st_q <= '0;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   assign fire = st_q.fire;

endmodule

// file: core/hom_top.sv
`timescale 1ns/1ps
module hom_top #(
   parameter int SOF_DELAY_CYCLES = hom_pkg::SOF_DELAY_CYCLES
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic ce,
   // processor port command, same clock
   input hom_pkg::hom_cmd_t cmd,
   // read answer
   output hom_pkg::hom_rsp_t rsp,
   // software reset command from the command register, one-cycle pulse
   input wire logic host_soft_reset_cmd,
   // resume-detected flag of the event status register, same clock
   input wire logic resume_detected_flag,
   // resume signalling seen on the bus, asynchronous pin
   input wire logic bus_resume_pin,
   output logic remote_wake_enable,
   output logic remote_wake_connected,
   output hom_pkg::hom_fs_t host_functional_state,
   output logic remote_wakeup,
   output logic sof_active,
   output logic frame_start_set,
   output logic soft_reset_done
);

   hom_pkg::hom_state_t st_q;
   hom_pkg::hom_state_t st_d;

   logic is_read;
   logic is_write;
   logic sof_start;
   logic sof_abort;
   logic sof_fire;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // register image as read by the driver
   function automatic logic [31:0] pack_reg(input hom_pkg::hom_state_t s);
      logic [31:0] r;
      r = 32'h0000_0000;
      r[hom_pkg::RWE_BIT] = s.remote_wake_enable;
      r[hom_pkg::RWC_BIT] = s.remote_wake_connected;
      r[hom_pkg::FS_MSB:hom_pkg::FS_LSB] = s.host_functional_state;
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////
   // command decode
   assign is_read = cmd.valid && (cmd.code == hom_pkg::CMD_READ);
   assign is_write = cmd.valid && (cmd.code == hom_pkg::CMD_WRITE);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      st_d = st_q;
      st_d.rsp.valid = 1'b0;
      st_d.reset_done = 1'b0;

      // two-flop synchroniser for the bus resume pin
      st_d.resume_s1 = bus_resume_pin;
      st_d.resume_s2 = st_q.resume_s1;

      // read answers with the value held before this cycle
      if (is_read) begin
         st_d.rsp.valid = 1'b1;
         st_d.rsp.data = pack_reg(st_q);
      end

      // hardware move out of suspend on resume signalling
      if ((st_q.host_functional_state == hom_pkg::state_bus_suspend)
          && st_q.resume_s2) begin
         st_d.host_functional_state = hom_pkg::state_bus_resume;
      end

      // driver write; only path that touches the wake enable bit
      if (is_write) begin
         st_d.remote_wake_enable = cmd.data[hom_pkg::RWE_BIT];
         st_d.remote_wake_connected = cmd.data[hom_pkg::RWC_BIT];
         st_d.host_functional_state =
            hom_pkg::hom_fs_t'(cmd.data[hom_pkg::FS_MSB:hom_pkg::FS_LSB]);
      end

      // software reset: suspend, connected bit kept, done next cycle
      if (host_soft_reset_cmd) begin
         st_d.host_functional_state = hom_pkg::state_bus_suspend;
         st_d.remote_wake_connected = st_q.remote_wake_connected;
         st_d.reset_done = 1'b1;
      end

      // remote wake-up request; interrupt path never looks at this
      st_d.wakeup = st_q.remote_wake_enable && resume_detected_flag;

      // frame start generation follows operational state
      if (sof_fire) begin
         st_d.sof_active = 1'b1;
      end
      if (st_d.host_functional_state != hom_pkg::state_bus_operational) begin
         st_d.sof_active = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // operational entry and exit drive the start timer
   assign sof_start = ce
      && (st_d.host_functional_state == hom_pkg::state_bus_operational)
      && (st_q.host_functional_state != hom_pkg::state_bus_operational);
   assign sof_abort = ce
      && (st_d.host_functional_state != hom_pkg::state_bus_operational);

   hom_sof_timer #(
      .DELAY_CYCLES(SOF_DELAY_CYCLES)
   ) u_sof_timer (
      .mclk(mclk),
      .resetn(resetn),
      .ce(ce),
      .start(sof_start),
      .abort(sof_abort),
      .fire(sof_fire)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////
   // state register, frozen while ce is low
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st_q.remote_wake_enable <= hom_pkg::RWE_RESET;
         st_q.remote_wake_connected <= hom_pkg::RWC_RESET;
         st_q.host_functional_state <= hom_pkg::state_bus_reset;
         st_q.rsp.valid <= 1'b0;
         st_q.rsp.data <= hom_pkg::RD_RESET;
         st_q.wakeup <= 1'b0;
         st_q.sof_active <= 1'b0;
         st_q.reset_done <= 1'b0;
         st_q.resume_s1 <= 1'b0;
         st_q.resume_s2 <= 1'b0;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // outputs straight from flops
   assign rsp = st_q.rsp;
   assign remote_wake_enable = st_q.remote_wake_enable;
   assign remote_wake_connected = st_q.remote_wake_connected;
   assign host_functional_state = st_q.host_functional_state;
   assign remote_wakeup = st_q.wakeup;
   assign sof_active = st_q.sof_active;
   assign frame_start_set = sof_fire; // timer flop, one-cycle pulse
   assign soft_reset_done = st_q.reset_done;

endmodule

// file: bench/hom_top_props.sv
`timescale 1ns/1ps
module hom_top_props #(
   parameter int SOF_DELAY_CYCLES = hom_pkg::SOF_DELAY_CYCLES
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic ce,
   input hom_pkg::hom_cmd_t cmd,
   input hom_pkg::hom_rsp_t rsp,
   input wire logic host_soft_reset_cmd,
   input wire logic resume_detected_flag,
   input wire logic bus_resume_pin,
   input wire logic remote_wake_enable,
   input wire logic remote_wake_connected,
   input hom_pkg::hom_fs_t host_functional_state,
   input wire logic remote_wakeup,
   input wire logic sof_active,
   input wire logic frame_start_set,
   input wire logic soft_reset_done
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   logic rd_t, wr_t, sr_t;
   int run_q;
   // requests taken at this edge
   assign rd_t = ce && cmd.valid && cmd.code == hom_pkg::CMD_READ;
   assign wr_t = ce && cmd.valid && cmd.code == hom_pkg::CMD_WRITE;
   assign sr_t = ce && host_soft_reset_cmd;
   // cycles spent in operational
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         run_q <= 0;
      end else if (ce) begin
         run_q <= (host_functional_state == hom_pkg::state_bus_operational) ? run_q + 1 : 0;
      end
   end
   sequence s_read; rd_t; endsequence
   sequence s_write; wr_t && !sr_t; endsequence
   sequence s_soft; sr_t; endsequence
   a_read_image: assert property (s_read |=> rsp.valid && rsp.data == {21'h00_0000,
      $past(remote_wake_enable), $past(remote_wake_connected), 1'b0,
      $past(host_functional_state), 6'h00}) else $error("read image wrong");
   a_write_fields: assert property (s_write |=> remote_wake_enable == $past(cmd.data[10])
      && remote_wake_connected == $past(cmd.data[9])
      && host_functional_state == $past(cmd.data[7:6])) else $error("write not applied");
   a_soft_suspend: assert property (s_soft |=> soft_reset_done
      && host_functional_state == hom_pkg::state_bus_suspend) else $error("soft reset wrong");
   a_rwc_kept: assert property (s_soft ##0 !wr_t |=> $stable(remote_wake_connected))
      else $error("connected bit changed");
   a_wakeup_follow: assert property (ce |=> remote_wakeup ==
      $past(remote_wake_enable && resume_detected_flag)) else $error("wakeup wrong");
   a_own_change: assert property ($changed(host_functional_state) && !$past(wr_t)
      && !$past(sr_t) |-> $past(host_functional_state) == hom_pkg::state_bus_suspend
      && host_functional_state == hom_pkg::state_bus_resume) else $error("own state move");
   a_sof_delay: assert property (frame_start_set == (run_q == SOF_DELAY_CYCLES &&
      host_functional_state == hom_pkg::state_bus_operational)) else $error("frame start time");
   a_sof_active: assert property (frame_start_set ##1
      host_functional_state == hom_pkg::state_bus_operational |-> sof_active)
      else $error("sof not active");
   a_sof_clear: assert property (host_functional_state != hom_pkg::state_bus_operational
      |-> !sof_active) else $error("sof active outside operational");
endmodule
bind hom_top hom_top_props #(.SOF_DELAY_CYCLES(SOF_DELAY_CYCLES)) i_hom_top_props (.mclk, .resetn,
   .ce, .cmd, .rsp, .host_soft_reset_cmd, .resume_detected_flag, .bus_resume_pin,
   .remote_wake_enable, .remote_wake_connected, .host_functional_state, .remote_wakeup,
   .sof_active, .frame_start_set, .soft_reset_done);

// file: bench/hom_host.sv
`timescale 1ns/1ps
module hom_host (
   input wire logic mclk,
   input hom_pkg::hom_rsp_t rsp,
   output hom_pkg::hom_cmd_t cmd,
   output logic host_soft_reset_cmd
);
   // idle port at time zero
   initial begin
      cmd = '0;
      host_soft_reset_cmd = 1'b0;
   end
   // one command held to its taking edge, then data lines scrambled
   task automatic issue(input logic [7:0] code, input logic [31:0] data);
      @(posedge mclk);
      cmd <= '{1'b1, code, data};
      @(posedge mclk);
      cmd <= '{1'b0, ~code, ~data};
   endtask
   // read answer sampled away from the edge
   task automatic rd(output logic [31:0] data);
      issue(hom_pkg::CMD_READ, 32'h0000_0000);
      @(negedge mclk);
      data = (rsp.valid === 1'b1) ? rsp.data : 32'hdead_beef;
   endtask
   // one-cycle software reset request
   task automatic soft_reset;
      @(posedge mclk);
      host_soft_reset_cmd <= 1'b1;
      @(posedge mclk);
      host_soft_reset_cmd <= 1'b0;
   endtask
endmodule

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   localparam int SOFD = 8;
   typedef struct packed {logic [31:0] wdata; logic [31:0] image;} hom_row_t;
   logic mclk, resetn, ce, resume_detected_flag, bus_resume_pin, host_soft_reset_cmd;
   logic remote_wake_enable, remote_wake_connected, remote_wakeup, sof_active;
   logic frame_start_set, soft_reset_done;
   hom_pkg::hom_cmd_t cmd;
   hom_pkg::hom_rsp_t rsp;
   hom_pkg::hom_fs_t host_functional_state;
   int n_mismatch, checks;
   logic [31:0] got;
   hom_row_t rows [4] = '{'{32'h0000_0440, 32'h0000_0440}, '{32'h0000_0200, 32'h0000_0200},
      '{32'hffff_ffff, 32'h0000_06c0}, '{32'h0000_0000, 32'h0000_0000}};
   hom_top #(.SOF_DELAY_CYCLES(SOFD)) i_hom_top (.mclk, .resetn, .ce, .cmd, .rsp,
      .host_soft_reset_cmd, .resume_detected_flag, .bus_resume_pin, .remote_wake_enable,
      .remote_wake_connected, .host_functional_state, .remote_wakeup, .sof_active,
      .frame_start_set, .soft_reset_done);
   hom_host i_hom_host (.mclk, .rsp, .cmd, .host_soft_reset_cmd);
   // free-running clock
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // compare one value
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
      end
   endtask
   // verdict and end of run
   task automatic results;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // hang guard
   initial begin
      #16000;
      n_mismatch++;
      results();
   end
   // main sequence
   initial begin
      resetn = 1'b0;
      ce = 1'b1;
      resume_detected_flag = 1'b0;
      bus_resume_pin = 1'b0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      i_hom_host.rd(got);
      chk(got, 32'h0000_0000, "reset image");
      $display("reset test done");
      foreach (rows[i]) begin
         i_hom_host.issue(hom_pkg::CMD_WRITE, rows[i].wdata);
         i_hom_host.rd(got);
         chk(got, rows[i].image, "write then read");
      end
      i_hom_host.issue(8'h82, 32'hffff_ffff);
      i_hom_host.rd(got);
      chk(got, 32'h0000_0000, "foreign code");
      $display("table test done");
      i_hom_host.issue(hom_pkg::CMD_WRITE, 32'h0000_0680);
      i_hom_host.soft_reset();
      @(negedge mclk);
      chk({30'h0000_0000, host_functional_state}, 32'h0000_0003, "soft state");
      chk({31'h0000_0000, soft_reset_done}, 32'h0000_0001, "soft done");
      i_hom_host.rd(got);
      chk(got, 32'h0000_06c0, "after soft reset");
      $display("soft reset test done");
      @(posedge mclk);
      bus_resume_pin <= 1'b1;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk({30'h0000_0000, host_functional_state}, 32'h0000_0001, "resume move");
      @(posedge mclk);
      bus_resume_pin <= 1'b0;
      resume_detected_flag <= 1'b1;
      @(posedge mclk);
      @(negedge mclk);
      chk({31'h0000_0000, remote_wakeup}, 32'h0000_0001, "wakeup");
      $display("resume test done");
      i_hom_host.issue(hom_pkg::CMD_WRITE, 32'h0000_0480);
      repeat (SOFD - 1) @(posedge mclk);
      @(negedge mclk);
      chk({31'h0000_0000, frame_start_set}, 32'h0000_0000, "early frame start");
      @(negedge mclk);
      chk({31'h0000_0000, frame_start_set}, 32'h0000_0001, "frame start");
      @(negedge mclk);
      chk({31'h0000_0000, sof_active}, 32'h0000_0001, "sof active");
      $display("frame start test done");
      // clock enable low: a write is not taken and all state holds
      @(posedge mclk);
      ce <= 1'b0;
      i_hom_host.issue(hom_pkg::CMD_WRITE, 32'h0000_0000);
      @(posedge mclk);
      ce <= 1'b1;
      i_hom_host.rd(got);
      chk(got, 32'h0000_0480, "frozen by ce");
      chk({31'h0000_0000, sof_active}, 32'h0000_0001, "frozen sof");
      $display("clock enable test done");
      // hardware reset in mid-run clears both wake bits and the state
      i_hom_host.issue(hom_pkg::CMD_WRITE, 32'h0000_0680);
      @(negedge mclk);
      chk({30'h0000_0000, remote_wake_enable, remote_wake_connected}, 32'h0000_0003,
         "wake bits set");
      @(posedge mclk);
      resetn <= 1'b0;
      @(negedge mclk);
      chk({27'h000_0000, sof_active, remote_wake_enable, remote_wake_connected,
         host_functional_state}, 32'h0000_0000, "in reset");
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      i_hom_host.rd(got);
      chk(got, 32'h0000_0000, "after hardware reset");
      $display("mid-run reset test done");
      results();
   end
endmodule
